//--- bench/psc_board.sv
`timescale 1ns/10ps
module psc_board #(
  parameter int POR_CYC = 4000,
  parameter int WAKE_CYC = 5000
) (
  // Clock and requests from the bench
  input wire logic clk,
  input wire logic por_go,
  input wire logic wake_go,
  // Pins toward the block
  output logic por_n,
  output logic wake
);
  // Supervisor: long hold at power-up, short pulse on request
  initial begin
    por_n = 1'b0;
    repeat (POR_CYC) @(posedge clk);
    por_n <= 1'b1;
    forever begin
      @(posedge clk);
      if (por_go) begin
        por_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
      end
    end
  end
  // Wake source, only pulsed after blanking, held the full minimum
  initial begin
    wake = 1'b0;
    forever begin
      @(posedge clk);
      if (wake_go) begin
        wake <= 1'b1;
        repeat (WAKE_CYC) @(posedge clk);
        wake <= 1'b0;
      end
    end
  end
endmodule

//--- bench/test_psc_top.sv
`timescale 1ns/10ps
module test_psc_top;
  import psc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [31:0] prdata;
  logic pready, pslverr, err, por_go = 1'b0, wake_go = 1'b0, por_n, wake;
  logic pfail_n = 1'b1, main_battery_good = 1'b1, ext_n = 1'b1, nbat_n = 1'b1, urst_n = 1'b1;
  logic run, fast_interrupt_request, irq, srst_n, rtc_n, nobat, tact;
  logic [STRAP_W-1:0] strap;
  logic [TSEL_W-1:0] tsel;
  logic [TEST_W-1:0] tst_s = 2'h2;
  logic [PE_W-1:0] pe_s = 3'h5;
  logic [DRV_W-1:0] drv_s = 2'h1;
  logic [DD_W-1:0] dd_s = 4'ha;
  int bad_count = 0, checks_done = 0, rtc_lows = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  psc_top #(.BLANK_CYCLES(50), .FILT_LEN(4)) u_dut (.SYS_CLK(clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .POWER_FAIL_N(pfail_n),
    .MAIN_BATTERY_GOOD(main_battery_good), .EXTERNAL_SUPPLY_SENSE_N(ext_n),
    .NEW_BATTERY_SENSE_N(nbat_n), .POWER_ON_RESET_N(por_n), .USER_RESET_N(urst_n),
    .WAKEUP(wake), .TEST_MODE_STRAPS(tst_s), .PORT_E_STRAP(pe_s), .DRIVE_STRAP(drv_s),
    .DISPLAY_DATA_STRAP(dd_s), .RUN(run), .FAST_INTERRUPT_REQUEST(fast_interrupt_request), .IRQ(irq),
    .SYSTEM_RESET_N(srst_n), .RTC_RESET_N(rtc_n), .NO_BATTERY(nobat),
    .STRAP_VALUE(strap), .TEST_MODE_SEL(tsel), .TEST_ACTIVE(tact));
  psc_board u_board (.clk(clk), .por_go(por_go), .wake_go(wake_go), .por_n(por_n),
    .wake(wake));
  // Counts RTC reset cycles, since a short pulse falls between checks
  always @(posedge clk) if (!rtc_n) rtc_lows <= rtc_lows + 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk("pready", 1, 0);
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_wake();
    wake_go <= 1'b1;
    @(posedge clk) wake_go <= 1'b0;
    cyc(5040);
  endtask
  task automatic t_boot();
    chk("strap", 32'({4'ha, 2'h1, 3'h5, 2'h2, 1'b1}), 32'(strap));
    chk("tsel", 32'h5, 32'(tsel));
    chk("run", 0, 32'(run));
    pulse_wake();
    chk("run", 1, 32'(run));
    apb(1'b0, OFF_STAT, 0);
    chk("wake_ev", 1, 32'(rd[EV_WAKE]));
    apb(1'b1, OFF_STAT, 32'hf);
    $display("boot and wake done");
  endtask
  task automatic t_idle_pfail();
    apb(1'b1, OFF_CTRL, 32'h2);
    pulse_wake();
    apb(1'b0, OFF_STATE, 0);
    chk("state", 32'(ST_IDLE), 32'(rd[2:0]));
    chk("run", 1, 32'(run));
    pfail_n <= 1'b0;
    cyc(20);
    chk("run", 0, 32'(run));
    pfail_n <= 1'b1;
    main_battery_good <= 1'b0;
    cyc(20);
    pulse_wake();
    chk("run", 0, 32'(run));
    chk("fiq", 1, 32'(fast_interrupt_request));
    apb(1'b1, OFF_MASK, 32'h1);
    chk("irq", 1, 32'(irq));
    apb(1'b1, OFF_STAT, 32'hf);
    cyc(2);
    chk("fiq", 0, 32'(fast_interrupt_request));
    chk("irq", 0, 32'(irq));
    main_battery_good <= 1'b1;
    $display("idle and power fail done");
  endtask
  task automatic t_resets();
    int rtc0;
    ext_n <= 1'b0;
    nbat_n <= 1'b0;
    cyc(20);
    chk("nobat", 1, 32'(nobat));
    apb(1'b0, OFF_STATE, 0);
    chk("ext_sense", 0, 32'(rd[4+IN_EXTPWR]));
    ext_n <= 1'b1;
    nbat_n <= 1'b1;
    tst_s <= 2'h1;
    urst_n <= 1'b0;
    cyc(20);
    chk("sysrst", 0, 32'(srst_n));
    chk("rtc", 1, 32'(rtc_n));
    rtc0 = rtc_lows;
    por_go <= 1'b1;
    @(posedge clk) por_go <= 1'b0;
    cyc(20);
    chk("rtc_pulse", 1, 32'(rtc_lows != rtc0));
    chk("strap", 32'({4'ha, 2'h1, 3'h5, 2'h1, 1'b0}), 32'(strap));
    chk("tsel", 32'h2, 32'(tsel));
    chk("tact", 1, 32'(tact));
    urst_n <= 1'b1;
    apb(1'b0, 8'hfc, 0);
    chk("slverr", 1, 32'(err));
    $display("resets done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(16);
    rstn <= 1'b1;
    cyc(4100);
    t_boot();
    t_idle_pfail();
    t_resets();
    test_done();
  end
  // Watchdog
  initial begin
    #(25.0 * 60000);
    bad_count++;
    test_done();
  end
endmodule

//--- hdl/psc_pkg.sv
package psc_pkg;
  // Clock and timing
  localparam int CLK_KHZ = 40000;
  localparam int BLANK_MS = 2000;
  localparam int BLANK_CYC = BLANK_MS * CLK_KHZ;
  localparam int WAKE_MIN_US = 125;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_US * CLK_KHZ) / 1000;
  localparam int FILT_N = 4;
  // Pin indices; all but IN_POR are filtered
  localparam int IN_PFAIL = 0;
  localparam int IN_MAIN_BATTERY_GOOD = 1;
  localparam int IN_EXTPWR = 2;
  localparam int IN_NEWBAT = 3;
  localparam int IN_URST = 4;
  localparam int IN_WAKE = 5;
  localparam int NIN = 6;
  localparam int IN_POR = 6;
  localparam int PIN_W = 18;
  localparam logic [PIN_W-1:0] PIN_RST = 18'h0001f;
  localparam logic [NIN-1:0] FILT_RST = 6'h1f;
  // Strap layout: user reset, test, port E, drive, display data
  localparam int STRAP_W = 12;
  localparam int TEST_W = 2;
  localparam int PE_W = 3;
  localparam int DRV_W = 2;
  localparam int DD_W = 4;
  localparam int TSEL_W = 3;
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_STRAP = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  // Control and event bits
  localparam int CTL_STBY = 0;
  localparam int CTL_IDLE = 1;
  localparam int EV_BATT = 0;
  localparam int EV_PFAIL = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_NOBAT = 3;
  localparam int NEV = 4;
  localparam logic [NEV-1:0] MASK_RST = 4'h0;
  typedef enum logic [2:0] {
    ST_OPER = 3'b001,
    ST_IDLE = 3'b010,
    ST_STBY = 3'b100
  } psc_state_t;
endpackage

//--- hdl/psc_top.sv
// Notes on behaviour
// - Power fail forces Standby
// - Battery-good falling edge raises fast interrupt
// - Low battery-good in Standby blocks start-up
// - Low new-battery sense means no battery
// - Power-on reset clears everything, RTC included; STRAP_VALUE and PRDATA keep their values
// - Straps captured at power-on reset release
// - RUN high in Operating/Idle, low in Standby
// - Wake-up in Standby moves to Operating
// - Wake-up ignored in Idle and Operating
// - Wake-up blanked two seconds after power-on reset
// - User reset spares the RTC
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
module psc_top #(
  parameter int BLANK_CYCLES = psc_pkg::BLANK_CYC,
  parameter int FILT_LEN = psc_pkg::FILT_N
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Power pins
  input wire logic POWER_FAIL_N,
  input wire logic MAIN_BATTERY_GOOD,
  input wire logic EXTERNAL_SUPPLY_SENSE_N,
  input wire logic NEW_BATTERY_SENSE_N,
  input wire logic POWER_ON_RESET_N,
  input wire logic USER_RESET_N,
  input wire logic WAKEUP,
  // Strap pins
  input wire logic [psc_pkg::TEST_W-1:0] TEST_MODE_STRAPS,
  input wire logic [psc_pkg::PE_W-1:0] PORT_E_STRAP,
  input wire logic [psc_pkg::DRV_W-1:0] DRIVE_STRAP,
  input wire logic [psc_pkg::DD_W-1:0] DISPLAY_DATA_STRAP,
  // Status and reset outputs
  output logic RUN,
  output logic FAST_INTERRUPT_REQUEST,
  output logic IRQ,
  output logic SYSTEM_RESET_N,
  output logic RTC_RESET_N,
  output logic NO_BATTERY,
  output logic [psc_pkg::STRAP_W-1:0] STRAP_VALUE,
  output logic [psc_pkg::TSEL_W-1:0] TEST_MODE_SEL,
  output logic TEST_ACTIVE
);
  import psc_pkg::*;

  logic [PIN_W-1:0] pin_in, s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic [NIN-1:0] filt, filt_q_ff, nxt_filt_q;
  logic por_ok, sys_rst, usr_rst, soft_rst, por_q_ff, nxt_por_q, por_rise;
  logic [STRAP_W-1:0] strap_ff, nxt_strap;
  logic [31:0] blank_ff, nxt_blank;
  psc_state_t st_ff, nxt_st;
  logic run_ff, nxt_run, wake_ok, pending, wr, rd_setup;
  logic ctl_stby, ctl_idle;
  logic [NEV-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, ev, w1c;
  logic irq_ff, nxt_irq, fiq_ff, nxt_fiq, nobat_ff, nxt_nobat;
  logic srst_n_ff, nxt_srst_n, rtc_n_ff, nxt_rtc_n;
  logic [31:0] rdata_ff, nxt_rdata;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFF_CTRL) || (a == OFF_STATE) || (a == OFF_STRAP) ||
              (a == OFF_STAT) || (a == OFF_MASK);
  endfunction

  // Pins pass two flops first; straps are static but crossed the same way
  assign pin_in = {DISPLAY_DATA_STRAP, DRIVE_STRAP, PORT_E_STRAP, TEST_MODE_STRAPS,
                   POWER_ON_RESET_N, WAKEUP, USER_RESET_N, NEW_BATTERY_SENSE_N,
                   EXTERNAL_SUPPLY_SENSE_N, MAIN_BATTERY_GOOD, POWER_FAIL_N};
  always_comb begin
    nxt_s1 = pin_in;
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      s1_ff <= PIN_RST;
      s2_ff <= PIN_RST;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  // Power-on reset is not filtered, only synchronised
  assign por_ok = s2_ff[IN_POR];
  assign sys_rst = !RSTN || !por_ok;
  assign usr_rst = !filt[IN_URST];
  assign soft_rst = sys_rst || usr_rst;

  // Deglitch: level moves only after FILT_LEN equal samples
  generate
    for (genvar i = 0; i < NIN; i++) begin : g_filt
      logic [FILT_LEN-1:0] hist_ff, nxt_hist;
      logic f_ff, nxt_f;
      always_comb begin
        nxt_hist = {hist_ff[FILT_LEN-2:0], s2_ff[i]};
        nxt_f = f_ff;
        if (&hist_ff) begin
          nxt_f = 1'b1;
        end else if (~|hist_ff) begin
          nxt_f = 1'b0;
        end
        if (sys_rst) begin
          nxt_hist = {FILT_LEN{FILT_RST[i]}};
          nxt_f = FILT_RST[i];
        end
      end
      always_ff @(posedge SYS_CLK) begin
        hist_ff <= nxt_hist;
        f_ff <= nxt_f;
      end
      assign filt[i] = f_ff;
    end
  endgenerate

  // Edge history, strap capture and wake-up blanking
  always_comb begin
    nxt_filt_q = sys_rst ? FILT_RST : filt;
    nxt_por_q = RSTN ? por_ok : 1'b0;
    por_rise = por_ok && !por_q_ff;
    nxt_strap = RSTN ? strap_ff : '0;
    if (RSTN && por_rise) begin
      nxt_strap = {s2_ff[PIN_W-1:IN_POR+1], s2_ff[IN_URST]};
    end
    nxt_blank = blank_ff;
    if (sys_rst) begin
      nxt_blank = BLANK_CYCLES[31:0];
    end else if (blank_ff != 32'h0) begin
      nxt_blank = blank_ff - 32'h1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    filt_q_ff <= nxt_filt_q;
    por_q_ff <= nxt_por_q;
    strap_ff <= nxt_strap;
    blank_ff <= nxt_blank;
  end

  // Software requests from the control register
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign ctl_stby = wr && (PADDR == OFF_CTRL) && PWDATA[CTL_STBY];
  assign ctl_idle = wr && (PADDR == OFF_CTRL) && PWDATA[CTL_IDLE];
  assign pending = |(stat_ff & mask_ff) || stat_ff[EV_BATT];
  // Battery low and blanking both keep a wake-up from starting the system
  assign wake_ok = filt[IN_WAKE] && filt[IN_MAIN_BATTERY_GOOD] && (blank_ff == 32'h0);

  // Power state machine; power fail outranks everything but reset
  always_comb begin
    nxt_st = st_ff;
    if (sys_rst) begin
      nxt_st = ST_STBY;
    end else if (!filt[IN_PFAIL]) begin
      nxt_st = ST_STBY;
    end else if (usr_rst) begin
      // User reset is not a wake source, so Standby stays put
      nxt_st = (st_ff == ST_STBY) ? ST_STBY : ST_OPER;
    end else begin
      unique case (st_ff)
        ST_OPER: begin
          if (ctl_stby) begin
            nxt_st = ST_STBY;
          end else if (ctl_idle) begin
            nxt_st = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (ctl_stby) begin
            nxt_st = ST_STBY;
          end else if (pending) begin
            nxt_st = ST_OPER;
          end
        end
        ST_STBY: begin
          if (wake_ok) begin
            nxt_st = ST_OPER;
          end
        end
        default: nxt_st = ST_STBY;
      endcase
    end
    nxt_run = (nxt_st != ST_STBY);
  end
  always_ff @(posedge SYS_CLK) begin
    st_ff <= nxt_st;
    run_ff <= nxt_run;
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    ev = '0;
    ev[EV_BATT] = filt_q_ff[IN_MAIN_BATTERY_GOOD] && !filt[IN_MAIN_BATTERY_GOOD];
    ev[EV_PFAIL] = (st_ff != ST_STBY) && !filt[IN_PFAIL] && !sys_rst;
    ev[EV_WAKE] = (st_ff == ST_STBY) && (nxt_st == ST_OPER);
    ev[EV_NOBAT] = filt_q_ff[IN_NEWBAT] && !filt[IN_NEWBAT];
    w1c = (wr && PADDR == OFF_STAT) ? PWDATA[NEV-1:0] : '0;
    nxt_stat = (stat_ff & ~w1c) | ev;
    nxt_mask = (wr && PADDR == OFF_MASK) ? PWDATA[NEV-1:0] : mask_ff;
    if (soft_rst) begin
      nxt_stat = '0;
      nxt_mask = MASK_RST;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
    nxt_fiq = nxt_stat[EV_BATT];
    nxt_nobat = sys_rst ? 1'b0 : !filt[IN_NEWBAT];
  end
  always_ff @(posedge SYS_CLK) begin
    stat_ff <= nxt_stat;
    mask_ff <= nxt_mask;
    irq_ff <= nxt_irq;
    fiq_ff <= nxt_fiq;
    nobat_ff <= nxt_nobat;
  end

  // Reset outputs: user reset leaves the RTC running
  always_comb begin
    nxt_rtc_n = !sys_rst;
    nxt_srst_n = !soft_rst;
  end
  always_ff @(posedge SYS_CLK) begin
    rtc_n_ff <= nxt_rtc_n;
    srst_n_ff <= nxt_srst_n;
  end

  // Read data is fetched in the setup phase so the access needs no wait
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_setup) begin
      nxt_rdata = 32'h0;
      unique case (PADDR)
        // Status word is 11 bits wide; bit 11 and up read as zero
        OFF_STATE: nxt_rdata[10:0] = {blank_ff != 32'h0, filt, run_ff, st_ff};
        OFF_STRAP: nxt_rdata[STRAP_W-1:0] = strap_ff;
        OFF_STAT: nxt_rdata[NEV-1:0] = stat_ff;
        OFF_MASK: nxt_rdata[NEV-1:0] = mask_ff;
        default: nxt_rdata = 32'h0;
      endcase
    end
    if (!RSTN) begin
      nxt_rdata = 32'h0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    rdata_ff <= nxt_rdata;
  end

  assign PRDATA = rdata_ff;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok(PADDR);
  assign RUN = run_ff;
  assign FAST_INTERRUPT_REQUEST = fiq_ff;
  assign IRQ = irq_ff;
  assign SYSTEM_RESET_N = srst_n_ff;
  assign RTC_RESET_N = rtc_n_ff;
  assign NO_BATTERY = nobat_ff;
  assign STRAP_VALUE = strap_ff;
  // Test selection: captured user reset with the two test straps
  assign TEST_MODE_SEL = strap_ff[TSEL_W-1:0];
  assign TEST_ACTIVE = !strap_ff[0];

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  pfail_stby_a: assert property (por_ok && !filt[IN_PFAIL] |=> st_ff == ST_STBY && !RUN)
    else $error("power fail did not force standby");
  batt_fiq_a: assert property (por_ok && !usr_rst && $fell(filt[IN_MAIN_BATTERY_GOOD])
    |=> FAST_INTERRUPT_REQUEST && stat_ff[EV_BATT])
    else $error("battery fall gave no fast interrupt");
  batt_hold_a: assert property (st_ff == ST_STBY && !filt[IN_MAIN_BATTERY_GOOD] |=> st_ff == ST_STBY)
    else $error("start-up with battery low");
  nobat_lvl_a: assert property (por_ok && $fell(filt[IN_NEWBAT]) |=> NO_BATTERY)
    else $error("no-battery not flagged");
  por_clear_a: assert property (!por_ok |=> st_ff == ST_STBY && stat_ff == '0 && !RTC_RESET_N)
    else $error("power-on reset left state");
  strap_cap_a: assert property (por_rise |=>
    strap_ff == ((STRAP_W'($past(s2_ff[PIN_W-1:IN_POR+1])) << 1) |
    STRAP_W'($past(s2_ff[IN_URST]))))
    else $error("straps not captured");
  run_state_a: assert property (RUN == (st_ff != ST_STBY))
    else $error("run pin disagrees with state");
  wake_go_a: assert property (por_ok && !usr_rst && st_ff == ST_STBY && wake_ok
    && filt[IN_PFAIL] |=> st_ff == ST_OPER ##1 (stat_ff[EV_WAKE] || !SYSTEM_RESET_N))
    else $error("wake-up did not start system");
  blank_hold_a: assert property (st_ff == ST_STBY && blank_ff != 32'h0 |=> st_ff == ST_STBY)
    else $error("wake-up acted during blanking");
  urst_rtc_a: assert property (por_ok && usr_rst |=> RTC_RESET_N && !SYSTEM_RESET_N)
    else $error("user reset touched the rtc");
endmodule
